// ### rtl/gpm_pkg.sv
// package with register map, field layout, function codes and timing for the pin function mux
package gpm_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [11:0] PIN_A_IDX = 12'h202;
    localparam logic [11:0] PIN_B_IDX = 12'h204;
    localparam logic [15:0] PIN_A_ADDR = {2'b00, PIN_A_IDX, 2'b00};
    localparam logic [15:0] PIN_B_ADDR = {2'b00, PIN_B_IDX, 2'b00};

    // field positions
    localparam int DIR_BIT = 15;
    localparam int PULLUP_BIT = 14;
    localparam int PULLDOWN_BIT = 13;
    localparam int INV_BIT = 10;
    localparam int DRIVE_BIT = 9;
    localparam int DEBOUNCE_BIT = 8;
    localparam int LEVEL_BIT = 6;
    localparam int FN_MSB = 4;

    // values after reset and writable bits
    localparam logic [15:0] PIN_A_RESET = 16'h0000;
    localparam logic [15:0] PIN_B_RESET = 16'h8100;
    localparam logic [15:0] PIN_A_MASK = 16'h045F;
    localparam logic [15:0] PIN_B_MASK = 16'hE75F;

    // function select codes
    localparam logic [4:0] FN_CLOCK = 5'h00;
    localparam logic [4:0] FN_LEVEL = 5'h01;
    localparam logic [4:0] FN_SERIAL_DATA = 5'h02;
    localparam logic [4:0] FN_IRQ = 5'h03;
    localparam logic [4:0] FN_OVER_TEMP = 5'h04;
    localparam logic [4:0] FN_LOOP2_LOCK = 5'h06;
    localparam logic [4:0] FN_LOOP3_LOCK = 5'h07;
    localparam logic [4:0] FN_FLL_LOCK = 5'h09;
    localparam logic [4:0] FN_COMPRESSOR = 5'h0A;
    localparam logic [4:0] FN_SEQ_DONE = 5'h0B;
    localparam logic [4:0] FN_NOISE_GATE = 5'h0C;
    localparam logic [4:0] FN_LIMITER = 5'h0D;
    localparam logic [4:0] FN_SATURATION = 5'h0E;
    localparam logic [4:0] FN_THRESHOLD = 5'h0F;
    localparam logic [4:0] FN_LEVEL_LOCK = 5'h10;
    localparam logic [4:0] FN_FIFO_ERROR = 5'h11;
    localparam logic [4:0] FN_OP_CLOCK = 5'h12;
    localparam logic [4:0] FN_MIC_CLOCK = 5'h13;
    localparam logic [4:0] FN_MIC_DATA = 5'h14;
    localparam logic [4:0] FN_MIC_DETECT = 5'h15;
    localparam logic [4:0] FN_MIC_SHORT = 5'h16;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEBOUNCE_NS = 200;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {GPM_IDLE, GPM_ACK} gpm_apb_state_t;
endpackage : gpm_pkg

// ### rtl/gpm_pin_if.sv
// interface between the register block and one pin source multiplexer
`timescale 1ns/1ns
interface gpm_pin_if;
    logic [4:0] fnSel;
    logic invert;
    logic level;
    logic [31:0] sources;
    logic pinValue;
    modport ctrl (output fnSel, output invert, output level, output sources, input pinValue);
    modport mux (input fnSel, input invert, input level, input sources, output pinValue);
endinterface : gpm_pin_if

// ### rtl/gpm_pin_mux.sv
// source selection and polarity for one pin
`timescale 1ns/1ns
module gpm_pin_mux
    import gpm_pkg::*;
(
    gpm_pin_if.mux pin
);
    // reserved codes see a zero in the source vector, so they give a quiet low before inversion
    always_comb begin
        if (pin.fnSel == FN_LEVEL) begin
            pin.pinValue = pin.level ^ pin.invert;
        end else begin
            pin.pinValue = pin.sources[pin.fnSel] ^ pin.invert;
        end
    end
endmodule : gpm_pin_mux

// ### rtl/gpm_debounce.sv
// input de-bounce filter: a new level is taken only after it has stood for a set number of cycles
`timescale 1ns/1ns
module gpm_debounce
    import gpm_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYC
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic rawIn,
    output logic cleanOut
);
    if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
        $error("debounce cycle count out of range");
    end

    logic stable_reg, stable_next;
    logic [7:0] count_reg, count_next;

    // count while the input differs from the held level, restart on any agreement
    always_comb begin
        stable_next = stable_reg;
        count_next = 8'h00;
        if (rawIn != stable_reg) begin
            if (count_reg == 8'(CYCLES - 1)) begin
                stable_next = rawIn;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stable_reg <= 1'b0;
            count_reg <= 8'h00;
        end else begin
            stable_reg <= stable_next;
            count_reg <= count_next;
        end
    end

    assign cleanOut = stable_reg;
endmodule : gpm_debounce

// ### rtl/gpm_pin_function_mux.sv
// register block, apb slave and pin drivers for the two general purpose pins
//
// Contract
// - each pin's invert bit 10 passes the selected signal when 0, inverts when 1.
// - first pin with level code drives its level bit 6 onto the pin.
// - first pin selector bits 4:0 reset zero; 0_0010 serial data, 0_0011 interrupt.
// - code 0_0000 on the first pin outputs the third loop or locked-loop clock.
// - code 0_0001 outputs a fixed 0 or 1 chosen by the level bit.
// - codes 0_0100, 0_0110, 0_0111, 0_1001 output temperature and lock indicators.
// - code 0_1010 compressor activity, 0_1011 sequencer done.
// - codes 0_1100 to 1_0000 output the level control indications.
// - code 1_0001 FIFO error, 1_0010 operating clock, 1_0011 microphone clock.
// - code 1_0101 microphone detect, 1_0110 microphone short circuit.
// - second pin direction bit 15: 0 output, 1 input; resets to input.
// - second pin bit 14 pull-up, bit 13 pull-down, bit 8 de-bounce, reset on.
// - second pin bit 9 selects push-pull when 0, open-drain when 1.
// - second pin level bit write sets output value, read returns pin input level.
// - second pin level bit reads undefined while the pin is an output.
// - second pin selector bits 4:0 reset to unused; other codes match the first pin.
// - second pin code 1_0100 carries microphone input data.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module gpm_pin_function_mux
    import gpm_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clockOutput,
    input wire logic serialAudioDataOut,
    input wire logic irqOut,
    input wire logic overTempShutdown,
    input wire logic secondPhaseLoopLock,
    input wire logic thirdPhaseLoopLock,
    input wire logic fllLock,
    input wire logic dynamicRangeCompressorActive,
    input wire logic sequencerDone,
    input wire logic automaticLevelControlNoiseGate,
    input wire logic automaticLevelControlOverload,
    input wire logic automaticLevelControlSaturation,
    input wire logic automaticLevelControlThreshold,
    input wire logic automaticLevelControlLock,
    input wire logic fifoError,
    input wire logic operatingClockOutput,
    input wire logic micClockOutput,
    input wire logic micDataInput,
    input wire logic micDetect,
    input wire logic micShort,
    output logic pinAOut,
    input wire logic pinBIn,
    output logic pinBOut,
    output logic pinBOutEn_n,
    output logic pinBPullUpEn,
    output logic pinBPullDownEn
);
    if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 255) begin : g_bad_debounce
        $error("DEBOUNCE_CYCLES out of range");
    end

    // byte-lane merge of a register write, limited to the writable bits
    function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        mergeWrite = (old & ~lanes) | (data[15:0] & lanes);
    endfunction : mergeWrite

    gpm_apb_state_t state_reg, state_next;
    logic [15:0] pinACfg_reg, pinACfg_next;
    logic [15:0] pinBCfg_reg, pinBCfg_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic pinAOut_reg, pinAOut_next;
    logic pinBOut_reg, pinBOut_next;
    logic pinBOutEn_n_reg, pinBOutEn_n_next;
    logic syncStage1_reg, syncStage2_reg;
    logic debounced;
    logic pinBLevelIn;
    logic hitA, hitB;
    logic [31:0] commonSources;
    logic [31:0] sourcesA, sourcesB;
    logic driveB;

    gpm_pin_if pinAIf();
    gpm_pin_if pinBIf();

    gpm_pin_mux u_mux_a (
        .pin(pinAIf.mux)
    );

    gpm_pin_mux u_mux_b (
        .pin(pinBIf.mux)
    );

    // internal sources are on this clock already, so no synchroniser on them;
    // clock sources are resampled at 20 MHz and only suit slow clocks
    always_comb begin
        commonSources = 32'h0000_0000;
        commonSources[FN_SERIAL_DATA] = serialAudioDataOut;
        commonSources[FN_IRQ] = irqOut;
        commonSources[FN_OVER_TEMP] = overTempShutdown;
        commonSources[FN_LOOP2_LOCK] = secondPhaseLoopLock;
        commonSources[FN_LOOP3_LOCK] = thirdPhaseLoopLock;
        commonSources[FN_FLL_LOCK] = fllLock;
        commonSources[FN_COMPRESSOR] = dynamicRangeCompressorActive;
        commonSources[FN_SEQ_DONE] = sequencerDone;
        commonSources[FN_NOISE_GATE] = automaticLevelControlNoiseGate;
        commonSources[FN_LIMITER] = automaticLevelControlOverload;
        commonSources[FN_SATURATION] = automaticLevelControlSaturation;
        commonSources[FN_THRESHOLD] = automaticLevelControlThreshold;
        commonSources[FN_LEVEL_LOCK] = automaticLevelControlLock;
        commonSources[FN_FIFO_ERROR] = fifoError;
        commonSources[FN_OP_CLOCK] = operatingClockOutput;
        commonSources[FN_MIC_CLOCK] = micClockOutput;
        commonSources[FN_MIC_DETECT] = micDetect;
        commonSources[FN_MIC_SHORT] = micShort;
        sourcesA = commonSources;
        sourcesA[FN_CLOCK] = clockOutput;
        sourcesB = commonSources;
        sourcesB[FN_MIC_DATA] = micDataInput;
    end

    // configuration to the two multiplexers
    assign pinAIf.fnSel = pinACfg_reg[FN_MSB:0];
    assign pinAIf.invert = pinACfg_reg[INV_BIT];
    assign pinAIf.level = pinACfg_reg[LEVEL_BIT];
    assign pinAIf.sources = sourcesA;
    assign pinBIf.fnSel = pinBCfg_reg[FN_MSB:0];
    assign pinBIf.invert = pinBCfg_reg[INV_BIT];
    assign pinBIf.level = pinBCfg_reg[LEVEL_BIT];
    assign pinBIf.sources = sourcesB;

    // second pin input: two-stage synchroniser, then the optional filter
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncStage1_reg <= 1'b0;
            syncStage2_reg <= 1'b0;
        end else begin
            syncStage1_reg <= pinBIn;
            syncStage2_reg <= syncStage1_reg;
        end
    end

    gpm_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clock(clock),
        .nrst(nrst),
        .rawIn(syncStage2_reg),
        .cleanOut(debounced)
    );

    // undefined readback while driving is returned as zero
    assign pinBLevelIn = pinBCfg_reg[DIR_BIT]
                         ? (pinBCfg_reg[DEBOUNCE_BIT] ? debounced : syncStage2_reg)
                         : 1'b0;

    // address decode
    assign hitA = (paddr == PIN_A_ADDR);
    assign hitB = (paddr == PIN_B_ADDR);

    // apb slave: one wait cycle, write lands on the edge that samples pready high
    always_comb begin
        state_next = state_reg;
        pinACfg_next = pinACfg_reg;
        pinBCfg_next = pinBCfg_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        unique case (state_reg)
            GPM_IDLE: begin
                if (psel && penable) begin
                    state_next = GPM_ACK;
                    pready_next = 1'b1;
                    pslverr_next = !(hitA || hitB);
                    prdata_next = 32'h0000_0000;
                    if (!pwrite && hitA) begin
                        // level bit of the first pin reads as zero
                        prdata_next[15:0] = pinACfg_reg & ~(16'h0001 << LEVEL_BIT);
                    end else if (!pwrite && hitB) begin
                        prdata_next[15:0] = pinBCfg_reg & ~(16'h0001 << LEVEL_BIT);
                        prdata_next[LEVEL_BIT] = pinBLevelIn;
                    end
                end
            end
            GPM_ACK: begin
                state_next = GPM_IDLE;
                if (psel && penable && pwrite) begin
                    if (hitA) begin
                        pinACfg_next = mergeWrite(pinACfg_reg, pwdata, pstrb, PIN_A_MASK);
                    end
                    if (hitB) begin
                        pinBCfg_next = mergeWrite(pinBCfg_reg, pwdata, pstrb, PIN_B_MASK);
                    end
                end
            end
        endcase
    end

    // second pin drive: direction first, then unused code, then drive type
    assign driveB = !pinBCfg_reg[DIR_BIT] && (pinBCfg_reg[FN_MSB:0] != FN_CLOCK);

    always_comb begin
        pinAOut_next = pinAIf.pinValue;
        if (!driveB) begin
            pinBOut_next = 1'b0;
            pinBOutEn_n_next = 1'b1;
        end else if (pinBCfg_reg[DRIVE_BIT]) begin
            // open drain: only a low is driven, a high releases the pin
            pinBOut_next = 1'b0;
            pinBOutEn_n_next = pinBIf.pinValue;
        end else begin
            pinBOut_next = pinBIf.pinValue;
            pinBOutEn_n_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= GPM_IDLE;
            pinACfg_reg <= PIN_A_RESET;
            pinBCfg_reg <= PIN_B_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            pinAOut_reg <= 1'b0;
            pinBOut_reg <= 1'b0;
            pinBOutEn_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            pinACfg_reg <= pinACfg_next;
            pinBCfg_reg <= pinBCfg_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            pinAOut_reg <= pinAOut_next;
            pinBOut_reg <= pinBOut_next;
            pinBOutEn_n_reg <= pinBOutEn_n_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pinAOut = pinAOut_reg;
    assign pinBOut = pinBOut_reg;
    assign pinBOutEn_n = pinBOutEn_n_reg;
    assign pinBPullUpEn = pinBCfg_reg[PULLUP_BIT];
    assign pinBPullDownEn = pinBCfg_reg[PULLDOWN_BIT];

    // checks on the pin paths and the register interface
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    logic [4:0] selA;
    logic [4:0] selB;
    logic invA;
    logic invB;
    assign selA = pinACfg_reg[FN_MSB:0];
    assign selB = pinBCfg_reg[FN_MSB:0];
    assign invA = pinACfg_reg[INV_BIT];
    assign invB = pinBCfg_reg[INV_BIT];

    sequence writeAccess(logic [15:0] addr);
        psel && !penable && pwrite && paddr == addr && pstrb[1:0] == 2'b11 ##1 psel && penable;
    endsequence

    sequence writeAck;
        pready_reg ##1 !pready_reg;
    endsequence

    invert_path_a: assert property (selA == FN_IRQ |=> pinAOut_reg == $past(irqOut ^ invA))
        else $error("first pin polarity or routing wrong");
    level_drive_a: assert property (selA == FN_LEVEL |=>
        pinAOut_reg == $past(pinACfg_reg[LEVEL_BIT] ^ invA))
        else $error("first pin level output wrong");
    serial_route_a: assert property (selA == FN_SERIAL_DATA
        |=> pinAOut_reg == $past(serialAudioDataOut ^ invA))
        else $error("serial data not routed");
    clock_route_a: assert property (selA == FN_CLOCK |=> pinAOut_reg == $past(clockOutput ^ invA))
        else $error("clock output not routed");
    lock_route_a: assert property (selA == FN_FLL_LOCK |=> pinAOut_reg == $past(fllLock ^ invA))
        else $error("lock indicator not routed");
    seq_route_a: assert property (selA == FN_SEQ_DONE |=> pinAOut_reg == $past(sequencerDone ^ invA))
        else $error("sequencer done not routed");
    limiter_route_a: assert property (selA == FN_LIMITER
        |=> pinAOut_reg == $past(automaticLevelControlOverload ^ invA))
        else $error("limiter overload not routed");
    fifo_route_a: assert property (selA == FN_FIFO_ERROR |=> pinAOut_reg == $past(fifoError ^ invA))
        else $error("fifo error not routed");
    mic_route_a: assert property (selA == FN_MIC_SHORT |=> pinAOut_reg == $past(micShort ^ invA))
        else $error("mic short not routed");
    input_release_a: assert property (pinBCfg_reg[DIR_BIT] |=> pinBOutEn_n_reg)
        else $error("second pin driven while input");
    // pready rises one edge after the first access edge, so the ack follows the access by one cycle
    pull_control_a: assert property (writeAccess(PIN_B_ADDR) ##1 writeAck
        |-> pinBPullUpEn == $past(pwdata[PULLUP_BIT], 2))
        else $error("pull-up bit not applied");
    open_drain_a: assert property (driveB && pinBCfg_reg[DRIVE_BIT] |=> !pinBOut_reg)
        else $error("open drain drove high");
    level_read_a: assert property (psel && penable && !pwrite && hitB && state_reg == GPM_IDLE
        && pinBCfg_reg[DIR_BIT] && !pinBCfg_reg[DEBOUNCE_BIT] |=> prdata_reg[LEVEL_BIT] == $past(syncStage2_reg))
        else $error("level readback wrong");
    output_read_a: assert property (pready_reg && !pinBCfg_reg[DIR_BIT] && $past(hitB)
        |-> !prdata_reg[LEVEL_BIT])
        else $error("level readback while output not zero");
    unused_idle_a: assert property (selB == FN_CLOCK |=> pinBOutEn_n_reg)
        else $error("unused second pin driven");
    mic_data_b_a: assert property (driveB && !pinBCfg_reg[DRIVE_BIT] && selB == FN_MIC_DATA
        |=> pinBOut_reg == $past(micDataInput ^ invB))
        else $error("mic data not routed to second pin");
    drive_order_a: assert property (driveB && !pinBCfg_reg[DRIVE_BIT]
        |=> !pinBOutEn_n_reg && pinBOut_reg == $past(pinBIf.pinValue))
        else $error("inverted value not driven");

    // second pin drive and bus answer checks
    pull_down_a: assert property (writeAccess(PIN_B_ADDR) ##1 writeAck
        |-> pinBPullDownEn == $past(pwdata[PULLDOWN_BIT], 2))
        else $error("pull-down bit not applied");
    invert_path_b_a: assert property (driveB && !pinBCfg_reg[DRIVE_BIT] && selB == FN_IRQ
        |=> pinBOut_reg == $past(irqOut ^ invB))
        else $error("second pin polarity or routing wrong");
    level_drive_b_a: assert property (driveB && !pinBCfg_reg[DRIVE_BIT] && selB == FN_LEVEL
        |=> pinBOut_reg == $past(pinBCfg_reg[LEVEL_BIT] ^ invB))
        else $error("second pin level output wrong");
    stray_access_a: assert property (psel && penable && state_reg == GPM_IDLE && !hitA && !hitB
        |=> pready_reg && pslverr_reg)
        else $error("unmapped access not refused");
endmodule : gpm_pin_function_mux

// ### verif/gpm_board.sv
// board logic on the second pin: resolves the wire from device drive, pulls and a board driver
`timescale 1ns/1ns
module gpm_board (
    input wire logic clock,
    input wire logic devOut,
    input wire logic devOutEn_n,
    input wire logic pullUp,
    input wire logic pullDown,
    input wire logic extDrive,
    input wire logic extValue,
    output logic pinLevel
);
    logic floatReg = 1'b0;
    // a wire nobody holds keeps changing, so a stale level never passes for a driven one
    always @(posedge clock) floatReg <= ~floatReg;
    // device drive wins, then the board driver, then the pulls
    always_comb begin
        if (!devOutEn_n) pinLevel = devOut;
        else if (extDrive) pinLevel = extValue;
        else if (pullUp) pinLevel = 1'b1;
        else if (pullDown) pinLevel = 1'b0;
        else pinLevel = floatReg;
    end
endmodule : gpm_board

// ### verif/gpm_pin_function_mux_bench.sv
// self-checking bench for the pin function mux: apb tasks, routing, drive and input tests
`timescale 1ns/1ns
module gpm_pin_function_mux_bench;
    import gpm_pkg::*;
    localparam int DB = 8;
    localparam logic [15:0] NO_REG = 16'h0814;
    logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd, srcVec = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, pinAOut, pinBIn, pinBOut, pinBOutEn_n, pinBPullUpEn, pinBPullDownEn, err;
    logic extDrive = 1'b1, extValue = 1'b0;
    logic [15:0] cfg;
    int err_total = 0, checked = 0;
    always #25 clock = ~clock;

    gpm_pin_function_mux #(.DEBOUNCE_CYCLES(DB)) u_gpm_pin_function_mux (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clockOutput(srcVec[0]), .serialAudioDataOut(srcVec[2]), .irqOut(srcVec[3]),
        .overTempShutdown(srcVec[4]), .secondPhaseLoopLock(srcVec[6]), .thirdPhaseLoopLock(srcVec[7]),
        .fllLock(srcVec[9]), .dynamicRangeCompressorActive(srcVec[10]), .sequencerDone(srcVec[11]),
        .automaticLevelControlNoiseGate(srcVec[12]), .automaticLevelControlOverload(srcVec[13]),
        .automaticLevelControlSaturation(srcVec[14]), .automaticLevelControlThreshold(srcVec[15]),
        .automaticLevelControlLock(srcVec[16]), .fifoError(srcVec[17]), .operatingClockOutput(srcVec[18]),
        .micClockOutput(srcVec[19]), .micDataInput(srcVec[20]), .micDetect(srcVec[21]), .micShort(srcVec[22]),
        .pinAOut(pinAOut), .pinBIn(pinBIn), .pinBOut(pinBOut), .pinBOutEn_n(pinBOutEn_n),
        .pinBPullUpEn(pinBPullUpEn), .pinBPullDownEn(pinBPullDownEn));
    gpm_board u_gpm_board (.clock(clock), .devOut(pinBOut), .devOutEn_n(pinBOutEn_n), .pullUp(pinBPullUpEn),
        .pullDown(pinBPullDownEn), .extDrive(extDrive), .extValue(extValue), .pinLevel(pinBIn));

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high, bounded wait
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(name, rd, exp);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // codes that carry a source: level, reserved and the pin-specific gaps carry none
    function automatic logic routed(input int c, input logic pinB);
        return !(c == 1 || c == 5 || c == 8 || c > 22 || (c == 0 && pinB) || (c == 20 && !pinB));
    endfunction : routed

    initial begin
        tick(6);
        chk("reset pins", {pinAOut, pinBOut, pinBOutEn_n, pinBPullUpEn, pinBPullDownEn}, 32'h4);
        nrst <= 1'b1;
        rdchk("a reset", PIN_A_ADDR, 32'h0);
        rdchk("b reset", PIN_B_ADDR, 32'h8100);
        wr(NO_REG, 32'hFFFF);
        chk("stray write err", err, 32'h1);
        rdchk("stray read", NO_REG, 32'h0);
        chk("stray read err", err, 32'h1);
        // low strobe only: the high byte must stay clear
        // selector fields stay on codes that software may program
        apb(1'b1, PIN_A_ADDR, 32'hFFF6, 4'h1);
        rdchk("a low strobe", PIN_A_ADDR, 32'h0016);
        wr(PIN_A_ADDR, 32'hFFF6);
        rdchk("a mask", PIN_A_ADDR, 32'h0416);
        wr(PIN_B_ADDR, 32'h7FF6);
        rdchk("b output mask", PIN_B_ADDR, 32'h6716);
        chk("b pulls both", {pinBPullUpEn, pinBPullDownEn}, 32'h3);
        // every code software may use, both polarities; the selected source is set against all others
        // the first pin holds its level code (level 0) where the second pin takes microphone data
        for (int c = 0; c < 23; c++) begin
            if (c == 5 || c == 8) continue;
            for (int inv = 0; inv < 2; inv++) begin
                cfg = {5'h00, inv[0], 5'h00, c[4:0]};
                wr(PIN_A_ADDR, {16'h0000, cfg[15:5], ((c == 20) ? FN_LEVEL : cfg[4:0])});
                wr(PIN_B_ADDR, {16'h0000, cfg});
                for (int v = 0; v < 2; v++) begin
                    srcVec <= v[0] ? (32'h1 << c) : ~(32'h1 << c);
                    tick(2);
                    chk("a route", pinAOut, (routed(c, 1'b0) && v == 1) ^ inv[0]);
                    chk("b release", pinBOutEn_n, c == 0);
                    if (c != 0) chk("b route", pinBOut, (routed(c, 1'b1) && v == 1) ^ inv[0]);
                end
            end
        end
        wr(PIN_A_ADDR, 32'h0041);
        wr(PIN_B_ADDR, 32'h0041);
        tick(2);
        chk("a level", pinAOut, 32'h1);
        chk("b level", {pinBOutEn_n, pinBOut}, 32'h1);
        wr(PIN_A_ADDR, 32'h0401);
        tick(2);
        chk("a level inv", pinAOut, 32'h1);
        // open drain with the board pull-up: low is driven, high is released
        extDrive <= 1'b0;
        wr(PIN_B_ADDR, 32'h4201);
        tick(2);
        chk("od low", {pinBOutEn_n, pinBIn}, 32'h0);
        wr(PIN_B_ADDR, 32'h4241);
        tick(2);
        chk("od high", {pinBOutEn_n, pinBIn}, 32'h3);
        wr(PIN_B_ADDR, 32'h4601);
        tick(2);
        chk("od inverted", pinBOutEn_n, 32'h1);
        wr(PIN_B_ADDR, 32'hA000);
        tick(4);
        chk("b pull down", {pinBPullUpEn, pinBPullDownEn}, 32'h1);
        rdchk("b pulled low", PIN_B_ADDR, 32'hA000);
        wr(PIN_B_ADDR, 32'hC000);
        tick(4);
        rdchk("b pulled high", PIN_B_ADDR, 32'hC040);
        // reset in mid-run brings back the input state
        nrst <= 1'b0;
        tick(2);
        chk("reset again", {pinBOutEn_n, pinBPullUpEn, pinBPullDownEn}, 32'h4);
        nrst <= 1'b1;
        extDrive <= 1'b1;
        rdchk("b reset again", PIN_B_ADDR, 32'h8100);
        wr(PIN_B_ADDR, 32'h8000);
        extValue <= 1'b1;
        tick(4);
        rdchk("b input high", PIN_B_ADDR, 32'h8040);
        // filter on: a three-cycle dip is dropped, a lasting change lands late
        wr(PIN_B_ADDR, 32'h8100);
        extValue <= 1'b0;
        tick(3);
        extValue <= 1'b1;
        tick(2 * DB);
        rdchk("glitch dropped", PIN_B_ADDR, 32'h8140);
        extValue <= 1'b0;
        rdchk("filter holds", PIN_B_ADDR, 32'h8140);
        tick(2 * DB);
        rdchk("filter settled", PIN_B_ADDR, 32'h8100);
        results();
    end
endmodule : gpm_pin_function_mux_bench
